// *** bpt_pkg.sv ***
// Package with register map, field positions and modes of the breakpoint and tagging block.
package bpt_pkg;
  // ==========================================================================
  // Register byte addresses (APB, one aligned word each).
  localparam logic [7:0] ADDR_CTRL0     = 8'h80;
  localparam logic [7:0] ADDR_CTRL1     = 8'h84;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'h88;
  localparam logic [7:0] ADDR_ADDR_LOW  = 8'h8C;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h90;
  localparam logic [7:0] ADDR_DATA_LOW  = 8'h94;
  localparam logic [7:0] ADDR_STATUS    = 8'h98;
  // Printed register indices; byte address is four times these.
  localparam logic [7:0] IDX_CTRL0      = 8'h20;
  localparam logic [7:0] IDX_CTRL1      = 8'h21;
  localparam logic [7:0] IDX_ADDR_HIGH  = 8'h22;
  localparam logic [7:0] IDX_ADDR_LOW   = 8'h23;
  localparam logic [7:0] IDX_DATA_HIGH  = 8'h24;
  localparam logic [7:0] IDX_DATA_LOW   = 8'h25;
  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // ==========================================================================
  // Control register 0 fields.
  localparam int MODE_HI_BIT      = 7;
  localparam int MODE_LO_BIT      = 6;
  localparam int PROG_ONLY_BIT    = 5;
  localparam int BP1_RANGE_BIT    = 3;
  localparam int BP0_RANGE_BIT    = 2;
  localparam logic [7:0] CTRL0_WMASK = 8'hEC;
  // Control register 1 fields.
  localparam int DCMP_EN_BIT      = 6;
  localparam int DMASK_HI_BIT     = 5;
  localparam int DMASK_LO_BIT     = 4;
  localparam int BP1_QUAL_BIT     = 3;
  localparam int BP1_TYPE_BIT     = 2;
  localparam int BP0_QUAL_BIT     = 1;
  localparam int BP0_TYPE_BIT     = 0;
  localparam logic [7:0] CTRL1_WMASK = 8'h7F;
  // ==========================================================================
  // Breakpoint modes.
  typedef enum logic [1:0]
  {
    MODE_OFF,
    MODE_SWI_DUAL,
    MODE_BDM_FULL,
    MODE_BDM_DUAL
  } bpt_mode_t;
  // Tagging control states.
  typedef enum logic [1:0]
  {
    TAG_IDLE,
    TAG_ARMED,
    TAG_HALT
  } bpt_tag_state_t;
  localparam int QUEUE_DEPTH = 4;
endpackage

// *** bpt_tag_queue.sv ***
// Small instruction queue memory carrying program bytes with their tag bits.
`timescale 1ns/1ps
`default_nettype none
module bpt_tag_queue
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        push,
  input  wire logic [17:0] push_word,
  input  wire logic        pop,
  output var  logic [17:0] head_word,
  output var  logic        head_valid
);
  // ==========================================================================
  // Storage.
  logic [17:0] mem_q [bpt_pkg::QUEUE_DEPTH];
  logic [17:0] mem_d [bpt_pkg::QUEUE_DEPTH];
  logic [1:0]  wr_q, wr_d, rd_q, rd_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [17:0] head_d;
  logic        hv_d;

  // Pointers, count and registered head; a full queue drops pushes, the CPU never overfills it.
  always_comb
  begin
    mem_d  = mem_q;
    wr_d   = wr_q;
    rd_d   = rd_q;
    cnt_d  = cnt_q;
    if (pop && cnt_q != 3'h0)
    begin
      rd_d  = rd_q + 2'h1;
      cnt_d = cnt_d - 3'h1;
    end
    if (push && cnt_q != 3'h4)
    begin
      mem_d[wr_q] = push_word;
      wr_d        = wr_q + 2'h1;
      cnt_d       = cnt_d + 3'h1;
    end
    head_d = mem_d[rd_d];
    hv_d   = cnt_d != 3'h0;
  end

  // Registers only.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < bpt_pkg::QUEUE_DEPTH; i++)
        mem_q[i] <= 18'h0_0000;
      wr_q       <= 2'h0;
      rd_q       <= 2'h0;
      cnt_q      <= 3'h0;
      head_word  <= 18'h0_0000;
      head_valid <= 1'b0;
    end
    else
    begin
      mem_q      <= mem_d;
      wr_q       <= wr_d;
      rd_q       <= rd_d;
      cnt_q      <= cnt_d;
      head_word  <= head_d;
      head_valid <= hv_d;
    end
  end
endmodule
`default_nettype wire

// *** bpt_breakpoint.sv ***
// Breakpoint compare, direction qualification and instruction tagging unit with APB registers.
`timescale 1ns/1ps
`default_nettype none
module bpt_breakpoint
(
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // CPU bus cycle under watch.
  input  wire logic        bus_valid,
  input  wire logic [15:0] bus_addr,
  input  wire logic [15:0] bus_data,
  input  wire logic        bus_read,
  // Program fetch into the instruction queue and its retirement.
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_word,
  input  wire logic        instr_retire,
  // Debug control.
  input  wire logic        tag_go_command,
  input  wire logic        background_debug_mode,
  input  wire logic        bus_clock_out,
  // Shared pins (inputs come from outside the clock domain).
  input  wire logic        low_byte_strobe,
  input  wire logic        background_serial_pin,
  // Results.
  output var  logic        breakpoint_zero,
  output var  logic        breakpoint_one,
  output var  logic        swi_request,
  output var  logic        tag_enter_background,
  output var  logic        serial_cmd_enable,
  output var  logic        tagging_active,
  output var  logic [15:0] head_instr
);
  // ==========================================================================
  // Register state.
  logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
  logic [7:0] ah_q, ah_d, al_q, al_d, dh_q, dh_d, dl_q, dl_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;
  logic        access;

  // Matches the printed index scaled to a byte address.
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:10] == 22'h0) && (a[9:0] == {idx, 2'b00});
  endfunction

  // Compare one byte; a disabled compare always agrees.
  function automatic logic byte_ok(input logic en, input logic [7:0] r, input logic [7:0] b);
    byte_ok = !en || (r == b);
  endfunction

  // Direction check: qualification off ignores the bus; 0 selects writes, 1 reads.
  function automatic logic dir_ok(input logic qual, input logic typ, input logic rd);
    dir_ok = !qual || (typ == rd);
  endfunction

  assign access = psel && penable;

  // ==========================================================================
  // APB decode; answer after one wait state, unmapped addresses read zero with an error.
  always_comb
  begin
    ctrl0_d   = ctrl0_q;
    ctrl1_d   = ctrl1_q;
    ah_d      = ah_q;
    al_d      = al_q;
    dh_d      = dh_q;
    dl_d      = dl_q;
    prdata_d  = 32'h0000_0000;
    pready_d  = access && !pready;
    pslverr_d = 1'b0;
    if (access && !pready)
    begin
      if (hit(paddr, bpt_pkg::IDX_CTRL0))
      begin
        prdata_d = {24'h00_0000, ctrl0_q};
        if (pwrite)
          ctrl0_d = pwdata[7:0] & bpt_pkg::CTRL0_WMASK;
      end
      else if (hit(paddr, bpt_pkg::IDX_CTRL1))
      begin
        prdata_d = {24'h00_0000, ctrl1_q};
        if (pwrite)
          ctrl1_d = pwdata[7:0] & bpt_pkg::CTRL1_WMASK;
      end
      else if (hit(paddr, bpt_pkg::IDX_ADDR_HIGH))
      begin
        prdata_d = {24'h00_0000, ah_q};
        if (pwrite)
          ah_d = pwdata[7:0];
      end
      else if (hit(paddr, bpt_pkg::IDX_ADDR_LOW))
      begin
        prdata_d = {24'h00_0000, al_q};
        if (pwrite)
          al_d = pwdata[7:0];
      end
      else if (hit(paddr, bpt_pkg::IDX_DATA_HIGH))
      begin
        prdata_d = {24'h00_0000, dh_q};
        if (pwrite)
          dh_d = pwdata[7:0];
      end
      else if (hit(paddr, bpt_pkg::IDX_DATA_LOW))
      begin
        prdata_d = {24'h00_0000, dl_q};
        if (pwrite)
          dl_d = pwdata[7:0];
      end
      else if (paddr == {24'h00_0000, bpt_pkg::ADDR_STATUS})
        prdata_d = {28'h000_0000, tagging_active, tag_enter_background, breakpoint_one, breakpoint_zero};
      else
        pslverr_d = 1'b1;
    end
  end

  // ==========================================================================
  // Breakpoint comparison.
  bpt_pkg::bpt_mode_t mode;
  logic dual, full, m_ah, m_al, m_dh, m_dl, bp0_d, bp1_d, swi_d, bp_en;

  always_comb
  begin
    mode  = bpt_pkg::bpt_mode_t'({ctrl0_q[bpt_pkg::MODE_HI_BIT], ctrl0_q[bpt_pkg::MODE_LO_BIT]});
    dual  = (mode == bpt_pkg::MODE_SWI_DUAL) || (mode == bpt_pkg::MODE_BDM_DUAL);
    full  = (mode == bpt_pkg::MODE_BDM_FULL);
    // Breakpoints are held off while the CPU runs background code.
    bp_en = bus_valid && !background_debug_mode;
    m_ah  = byte_ok(1'b1, ah_q, bus_addr[15:8]);
    m_al  = byte_ok(ctrl0_q[bpt_pkg::BP0_RANGE_BIT], al_q, bus_addr[7:0]);
    m_dh  = full ? byte_ok(ctrl1_q[bpt_pkg::DCMP_EN_BIT] && !ctrl1_q[bpt_pkg::DMASK_HI_BIT],
                           dh_q, bus_data[15:8])
                 : byte_ok(1'b1, dh_q, bus_addr[15:8]);
    m_dl  = full ? byte_ok(ctrl1_q[bpt_pkg::DCMP_EN_BIT] && !ctrl1_q[bpt_pkg::DMASK_LO_BIT],
                           dl_q, bus_data[7:0])
                 : byte_ok(ctrl0_q[bpt_pkg::BP1_RANGE_BIT], dl_q, bus_addr[7:0]);
    bp0_d = 1'b0;
    bp1_d = 1'b0;
    swi_d = 1'b0;
    case (mode)
      bpt_pkg::MODE_OFF:
        bp0_d = 1'b0;
      bpt_pkg::MODE_BDM_FULL:
        bp0_d = bp_en && m_ah && m_al && m_dh && m_dl
              && dir_ok(ctrl1_q[bpt_pkg::BP0_QUAL_BIT], ctrl1_q[bpt_pkg::BP0_TYPE_BIT], bus_read);
      bpt_pkg::MODE_BDM_DUAL:
      begin
        bp0_d = bp_en && m_ah && m_al
              && dir_ok(ctrl1_q[bpt_pkg::BP0_QUAL_BIT], ctrl1_q[bpt_pkg::BP0_TYPE_BIT], bus_read);
        bp1_d = bp_en && ctrl1_q[bpt_pkg::DCMP_EN_BIT] && m_dh && m_dl
              && dir_ok(ctrl1_q[bpt_pkg::BP1_QUAL_BIT], ctrl1_q[bpt_pkg::BP1_TYPE_BIT], bus_read);
      end
      bpt_pkg::MODE_SWI_DUAL:
      begin
        // Direction bits do not apply in the software interrupt mode.
        bp0_d = bp_en && m_ah && m_al;
        bp1_d = bp_en && ctrl1_q[bpt_pkg::DCMP_EN_BIT] && m_dh && m_dl;
        swi_d = bp0_d || bp1_d;
      end
      default:
        bp0_d = 1'b0;
    endcase
    if (!dual)
      bp1_d = 1'b0;
  end

  // ==========================================================================
  // Tag pin synchronisers and bus clock fall detection.
  logic [1:0] lo_sync_q, hi_sync_q, clk_sync_q;
  logic       clk_prev_q, tag_lo_q, tag_hi_q, tag_lo_d, tag_hi_d, fall;
  bpt_pkg::bpt_tag_state_t tstate_q, tstate_d;
  logic       enter_d;
  logic [17:0] head_word;
  logic        head_valid;

  assign fall = clk_prev_q && !clk_sync_q[1];

  // Tag state: armed by the tag-go command outside background mode, dropped when background mode starts.
  always_comb
  begin
    tstate_d = tstate_q;
    tag_lo_d = tag_lo_q;
    tag_hi_d = tag_hi_q;
    enter_d  = 1'b0;
    if (tstate_q == bpt_pkg::TAG_ARMED && fall)
    begin
      tag_lo_d = !lo_sync_q[1];
      tag_hi_d = !hi_sync_q[1];
    end
    case (tstate_q)
      bpt_pkg::TAG_IDLE:
      begin
        // Tags latched in an earlier session must not mark fetches after the next tag-go.
        tag_lo_d = 1'b0;
        tag_hi_d = 1'b0;
        if (tag_go_command && !background_debug_mode)
          tstate_d = bpt_pkg::TAG_ARMED;
      end
      bpt_pkg::TAG_ARMED:
        if (background_debug_mode)
          tstate_d = bpt_pkg::TAG_IDLE;
        else if (head_valid && (head_word[17] || head_word[16]))
        begin
          tstate_d = bpt_pkg::TAG_HALT;
          enter_d  = 1'b1;
        end
      bpt_pkg::TAG_HALT:
        if (background_debug_mode)
          tstate_d = bpt_pkg::TAG_IDLE;
        else
          enter_d = 1'b1;
      default:
        tstate_d = bpt_pkg::TAG_IDLE;
    endcase
  end

  // Tagged instruction queue; a tagged head is held, not retired.
  bpt_tag_queue u_queue
  (
    .clk        (clk),
    .reset      (reset),
    .push       (fetch_valid),
    .push_word  ({tag_hi_q && tstate_q == bpt_pkg::TAG_ARMED,
                  tag_lo_q && tstate_q == bpt_pkg::TAG_ARMED, fetch_word}),
    .pop        (instr_retire && !enter_d),
    .head_word  (head_word),
    .head_valid (head_valid)
  );

  // ==========================================================================
  // All registers.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl0_q    <= bpt_pkg::RESET_BYTE;
      ctrl1_q    <= bpt_pkg::RESET_BYTE;
      ah_q       <= bpt_pkg::RESET_BYTE;
      al_q       <= bpt_pkg::RESET_BYTE;
      dh_q       <= bpt_pkg::RESET_BYTE;
      dl_q       <= bpt_pkg::RESET_BYTE;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      breakpoint_zero      <= 1'b0;
      breakpoint_one       <= 1'b0;
      swi_request          <= 1'b0;
      lo_sync_q  <= 2'b11;
      hi_sync_q  <= 2'b11;
      clk_sync_q <= 2'b00;
      clk_prev_q <= 1'b0;
      tag_lo_q   <= 1'b0;
      tag_hi_q   <= 1'b0;
      tstate_q   <= bpt_pkg::TAG_IDLE;
      tag_enter_background <= 1'b0;
      serial_cmd_enable    <= 1'b1;
      tagging_active       <= 1'b0;
      head_instr <= 16'h0000;
    end
    else
    begin
      ctrl0_q    <= ctrl0_d;
      ctrl1_q    <= ctrl1_d;
      ah_q       <= ah_d;
      al_q       <= al_d;
      dh_q       <= dh_d;
      dl_q       <= dl_d;
      prdata     <= prdata_d;
      pready     <= pready_d;
      pslverr    <= pslverr_d;
      breakpoint_zero      <= bp0_d;
      breakpoint_one       <= bp1_d;
      swi_request          <= swi_d;
      lo_sync_q  <= {lo_sync_q[0], low_byte_strobe};
      hi_sync_q  <= {hi_sync_q[0], background_serial_pin};
      clk_sync_q <= {clk_sync_q[0], bus_clock_out};
      clk_prev_q <= clk_sync_q[1];
      tag_lo_q   <= tag_lo_d;
      tag_hi_q   <= tag_hi_d;
      tstate_q   <= tstate_d;
      tag_enter_background <= enter_d;
      serial_cmd_enable    <= tstate_d == bpt_pkg::TAG_IDLE;
      tagging_active       <= tstate_d != bpt_pkg::TAG_IDLE;
      head_instr <= head_word[15:0];
    end
  end
endmodule
`default_nettype wire

// *** bpt_checker_sva.sv ***
// Port-level assertions for the breakpoint compare and tagging block.
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Checker module.
module bpt_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_valid,
  input wire logic tag_go_command,
  input wire logic background_debug_mode,
  input wire logic breakpoint_zero,
  input wire logic breakpoint_one,
  input wire logic swi_request,
  input wire logic tag_enter_background,
  input wire logic serial_cmd_enable,
  input wire logic tagging_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // An access phase still waiting for its answer.
  sequence apb_wait_s;
    psel && penable && !pready;
  endsequence
  // A tag-go request the block is free to take.
  sequence tag_go_ok_s;
    tag_go_command && !tagging_active && !background_debug_mode && !tag_enter_background;
  endsequence
  // Bus handshake: exactly one wait state, one-cycle answer.
  apb_latency_a: assert property (apb_wait_s |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  // A breakpoint needs a bus cycle the cycle before, and never fires in background mode.
  bp_needs_cycle_a: assert property ((breakpoint_zero || breakpoint_one) |-> $past(bus_valid))
    else $error("breakpoint without bus cycle");
  bp_bdm_block_a: assert property (background_debug_mode |=> !breakpoint_zero && !breakpoint_one)
    else $error("breakpoint in background mode");
  swi_pair_a: assert property (swi_request |-> breakpoint_zero || breakpoint_one)
    else $error("software interrupt without breakpoint");
  // Tagging start, stop and its effect on the serial command path.
  tag_start_a: assert property (tag_go_ok_s |=> tagging_active && !serial_cmd_enable)
    else $error("tag-go not taken");
  bdm_stops_tag_a: assert property (background_debug_mode |=> !tagging_active)
    else $error("tagging survived background mode");
  serial_block_a: assert property (tagging_active |-> !serial_cmd_enable)
    else $error("serial commands open while tagging");
  head_hold_a: assert property (tag_enter_background && !background_debug_mode |=> tag_enter_background)
    else $error("tagged head released early");
  // Reset values hold in the cycle after any reset edge, so no disable here.
  reset_vals_a: assert property (disable iff (1'b0) reset |=> serial_cmd_enable && !tagging_active && !pready)
    else $error("bad value after reset");
endmodule
bind bpt_breakpoint bpt_checker chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .bus_valid(bus_valid), .tag_go_command(tag_go_command),
  .background_debug_mode(background_debug_mode), .breakpoint_zero(breakpoint_zero),
  .breakpoint_one(breakpoint_one), .swi_request(swi_request), .tag_enter_background(tag_enter_background),
  .serial_cmd_enable(serial_cmd_enable), .tagging_active(tagging_active));
`default_nettype wire

// *** bpt_tag_host.sv ***
// Behavioural debug host that runs the bus clock pin and presents tag levels.
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Tag host model.
module bpt_tag_host
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] tag_want,
  output var  logic       bus_clock_out,
  output var  logic       low_byte_strobe,
  output var  logic       background_serial_pin
);
  logic [2:0] div_q = 3'h0;
  assign bus_clock_out = ~div_q[2];
  // Tags change only just after the bus clock rises, so they are steady at its fall.
  always @(posedge clk)
  begin
    div_q <= reset ? 3'h0 : div_q + 3'h1;
    if (reset)
      {background_serial_pin, low_byte_strobe} <= 2'h3;
    else if (div_q == 3'h0)
      {background_serial_pin, low_byte_strobe} <= tag_want;
  end
  initial {background_serial_pin, low_byte_strobe} = 2'h3;
endmodule
`default_nettype wire

// *** test_breakpoint_compare_and_tagging.sv ***
// Self-checking testbench of the breakpoint compare and tagging block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_breakpoint_compare_and_tagging;
  localparam logic [31:0] A_C0 = {22'h0, bpt_pkg::IDX_CTRL0, 2'b00};
  localparam logic [31:0] A_C1 = {22'h0, bpt_pkg::IDX_CTRL1, 2'b00};
  localparam logic [31:0] A_AH = {22'h0, bpt_pkg::IDX_ADDR_HIGH, 2'b00};
  localparam logic [31:0] A_AL = {22'h0, bpt_pkg::IDX_ADDR_LOW, 2'b00};
  localparam logic [31:0] A_DH = {22'h0, bpt_pkg::IDX_DATA_HIGH, 2'b00};
  localparam logic [31:0] A_DL = {22'h0, bpt_pkg::IDX_DATA_LOW, 2'b00};
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic bus_valid = 0, bus_read = 0, fetch_valid = 0, instr_retire = 0, tag_go_command = 0;
  logic [15:0] bus_addr = 0, bus_data = 0, fetch_word = 0, head_instr;
  logic background_debug_mode = 0, bus_clock_out, low_byte_strobe, background_serial_pin;
  logic breakpoint_zero, breakpoint_one, swi_request, tag_enter_background, serial_cmd_enable, tagging_active;
  logic [1:0] tag_want = 2'h3;
  int num_errors = 0, check_count = 0;
  logic [31:0] regs [4] = '{A_AH, A_AL, A_DH, A_DL};
  bpt_breakpoint dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_valid(bus_valid),
    .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .instr_retire(instr_retire), .tag_go_command(tag_go_command),
    .background_debug_mode(background_debug_mode), .bus_clock_out(bus_clock_out),
    .low_byte_strobe(low_byte_strobe), .background_serial_pin(background_serial_pin),
    .breakpoint_zero(breakpoint_zero), .breakpoint_one(breakpoint_one), .swi_request(swi_request),
    .tag_enter_background(tag_enter_background), .serial_cmd_enable(serial_cmd_enable),
    .tagging_active(tagging_active), .head_instr(head_instr));
  bpt_tag_host host (.clk(clk), .reset(reset), .tag_want(tag_want), .bus_clock_out(bus_clock_out),
    .low_byte_strobe(low_byte_strobe), .background_serial_pin(background_serial_pin));
  // ====================================================
  // Clock and run control.
  always #5 clk = ~clk;
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // A hung handshake must not stall the run forever.
  initial
  begin
    repeat (6000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  // ====================================================
  // Access tasks.
  // The request is held until pready is sampled high or 50 cycles pass; then it is released.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] er,
                     input logic ee);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (!w)
      `CHK("prdata", er, prdata)
    `CHK("pslverr", ee, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h00_0000, v}, 32'h0, 1'b0);
  endtask
  // One watched bus cycle; the breakpoint outputs answer one cycle later.
  task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic rd, input logic e0, input logic e1);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_data <= d;
    bus_read <= rd;
    @(posedge clk);
    bus_valid <= 1'b0;
    #1 `CHK("bp0", e0, breakpoint_zero)
    `CHK("bp1", e1, breakpoint_one)
  endtask
  // One-cycle strobe: 0 pushes a fetch, 1 retires the head, anything else is tag-go.
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: fetch_valid <= 1'b1;
      1: instr_retire <= 1'b1;
      default: tag_go_command <= 1'b1;
    endcase
    @(posedge clk);
    fetch_valid <= 1'b0;
    instr_retire <= 1'b0;
    tag_go_command <= 1'b0;
  endtask
  // ====================================================
  // Main sequence.
  initial
  begin
    int n;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, regs[i], 0, 32'h0, 1'b0);
      apb(1'b1, regs[i], 32'hFFFF_FF5A + i, 0, 1'b0);
      apb(1'b0, regs[i], 0, 32'h5A + i, 1'b0);
    end
    apb(1'b0, 32'h0000_0200, 0, 32'h0, 1'b1);
    wr(A_AH, 8'h12);
    wr(A_AL, 8'h34);
    wr(A_C0, 8'h84);
    wr(A_C1, 8'h03);
    cyc(16'h1234, 16'h0, 1, 1, 0);
    cyc(16'h1234, 16'h0, 0, 0, 0);
    cyc(16'h1235, 16'h0, 1, 0, 0);
    wr(A_C1, 8'h01);
    cyc(16'h1234, 16'h0, 0, 1, 0);
    wr(A_C1, 8'h00);
    cyc(16'h1234, 16'h0, 0, 1, 0);
    cyc(16'h1234, 16'h0, 1, 1, 0);
    wr(A_C0, 8'h80);
    cyc(16'h12FF, 16'h0, 1, 1, 0);
    wr(A_C1, 8'h40);
    wr(A_DH, 8'h56);
    wr(A_DL, 8'h78);
    cyc(16'h1200, 16'h5678, 1, 1, 0);
    cyc(16'h1200, 16'h5679, 1, 0, 0);
    cyc(16'h1300, 16'h5678, 1, 0, 0);
    wr(A_C1, 8'h50);
    cyc(16'h1200, 16'h5679, 1, 1, 0);
    wr(A_C1, 8'h60);
    cyc(16'h1200, 16'h9978, 1, 1, 0);
    wr(A_C0, 8'hC0);
    wr(A_C1, 8'h40);
    wr(A_DH, 8'hAB);
    cyc(16'hAB00, 16'h0, 1, 0, 1);
    cyc(16'h1200, 16'h0, 0, 1, 0);
    wr(A_C1, 8'h00);
    cyc(16'hAB00, 16'h0, 1, 0, 0);
    wr(A_C0, 8'hC8);
    wr(A_C1, 8'h48);
    cyc(16'hAB78, 16'h0, 0, 0, 1);
    cyc(16'hAB78, 16'h0, 1, 0, 0);
    cyc(16'hAB00, 16'h0, 0, 0, 0);
    // Software interrupt dual mode ignores the direction bits; mode off never matches.
    wr(A_C0, 8'h44);
    cyc(16'h1234, 16'h0, 1, 1, 0);
    `CHK("swi", 1'b1, swi_request)
    cyc(16'hAB00, 16'h0, 1, 0, 1);
    `CHK("swi", 1'b1, swi_request)
    wr(A_C0, 8'h04);
    cyc(16'h1234, 16'h0, 1, 0, 0);
    `CHK("swi", 1'b0, swi_request)
    background_debug_mode <= 1'b1;
    cyc(16'h1200, 16'h0, 0, 0, 0);
    background_debug_mode <= 1'b0;
    // Tags shown before tag-go must be ignored.
    tag_want <= 2'h0;
    fetch_word <= 16'h2222;
    pulse(0);
    repeat (30) @(posedge clk);
    `CHK("head", 16'h2222, head_instr)
    `CHK("enter_bg", 1'b0, tag_enter_background)
    pulse(1);
    pulse(2);
    #1 `CHK("tagging", 1'b1, tagging_active)
    `CHK("serial_en", 1'b0, serial_cmd_enable)
    repeat (20) @(posedge clk);
    fetch_word <= 16'h1111;
    pulse(0);
    for (n = 0; n < 40 && tag_enter_background !== 1'b1; n++) @(posedge clk);
    `CHK("enter_bg", 1'b1, tag_enter_background)
    `CHK("head", 16'h1111, head_instr)
    apb(1'b0, {24'h00_0000, bpt_pkg::ADDR_STATUS}, 0, 32'h0000_000C, 1'b0);
    tag_want <= 2'h3;
    pulse(1);
    repeat (2) @(posedge clk);
    `CHK("head", 16'h1111, head_instr)
    background_debug_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("tagging", 1'b0, tagging_active)
    `CHK("serial_en", 1'b1, serial_cmd_enable)
    wrap_up();
  end
endmodule
`default_nettype wire
